// file: rtl/pll_lock_consts.svh
/*
  Constants for the lock detect and divider control block: register offsets,
  field positions, reset values, encodings and counts.
  Assumes it is included by bare name from the design file.
*/
`ifndef PLL_LOCK_CONSTS_SVH
`define PLL_LOCK_CONSTS_SVH

// Register offsets (byte addresses on the 8-bit register port).
`define ADDR_R_LSB        8'h11
`define ADDR_R_MSB        8'h12
`define ADDR_A_CNT        8'h13
`define ADDR_B_LSB        8'h14
`define ADDR_B_MSB        8'h15
`define ADDR_PRESCALE     8'h16
`define ADDR_STATUS_SEL   8'h17
`define ADDR_LOCK_CFG     8'h18
`define ADDR_SYNC_DELAY   8'h19
`define ADDR_LD_SEL       8'h1a
`define ADDR_REFERENCE_MONITOR_PIN_SEL   8'h1b
`define ADDR_LIVE_STATUS  8'h20
`define ADDR_IRQ_STATUS   8'h21
`define ADDR_IRQ_MASK     8'h22
`define ADDR_DELAY_EN     8'h23

// Reset value of every writable register.
`define REG_RESET         8'h00

// Prescaler mode field and its fixed-divide / dual-modulus codes.
`define PRE_MODE_BITS     2:0
`define PRE_SHARED_RST    5
`define PRE_AB_RST        6
`define PRE_R_RST         7
`define PRE_DM2           3'h0
`define PRE_DM4           3'h1
`define PRE_DM8           3'h2
`define PRE_DM16          3'h3
`define PRE_DM32          3'h4
`define PRE_FD1           3'h5
`define PRE_FD2           3'h6
`define PRE_FD3           3'h7

// Status pin select and antibacklash field.
`define STAT_SEL_BITS     7:2
`define ABP_BITS          1:0

// Lock detect configuration.
`define LOCK_CNT_BITS     6:5
`define LOCK_WIN_BIT      4
`define DLD_DIS_BIT       3
`define LOCK_NEED_0       8'h05
`define LOCK_NEED_1       8'h10
`define LOCK_NEED_2       8'h40
`define LOCK_NEED_3       8'hff
`define LOCK_THR_HIGH     8'h03
`define LOCK_THR_LOW      8'h01

// Sync pin mode and the two delay codes.
`define SYNC_MODE_BITS    7:6
`define SYNC_MODE_OFF     2'h0
`define N_DLY_BITS        5:3
`define R_DLY_BITS        2:0
`define R_DLY_EN_BIT      0
`define N_DLY_EN_BIT      1

// Pin output select codes, shared by all three pin muxes.
`define PSEL_GROUND       6'h00
`define PSEL_DLD          6'h01
`define PSEL_CMP_HIGH     6'h02
`define PSEL_CMP_LOW      6'h03
`define PSEL_CURRENT_SRC  6'h04
`define PSEL_ALD_NCH      6'h05
`define PSEL_ALD_PCH      6'h06

// Interrupt status bit positions.
`define IRQ_LOCK_GAIN     0
`define IRQ_LOCK_LOSS     1
`define IRQ_CMP_RISE      2

// Edge gap saturation value; a gap this large is always out of window.
`define GAP_MAX           8'hff

`endif

// file: rtl/pll_lock_pkg.sv
/*
  Types shared by the lock detect and divider control block.
  Assumes the constants header is available by bare name.
*/
package pll_lock_pkg;
  // Phase gap meter state: idle, or waiting for the lagging edge.
  typedef enum logic [1:0] {
    GAP_IDLE     = 2'b00,
    GAP_WAIT_FB  = 2'b01,
    GAP_WAIT_REF = 2'b10
  } gap_state_type;
endpackage : pll_lock_pkg

// file: rtl/pulse_delay_tap.sv
/*
  Programmable delay cell for a divider output pulse: the pulse leaves one
  cycle after it arrives, plus a selectable tap of extra cycles when enabled.
  Assumes one clock and pulses of one cycle.
*/
module pulse_delay_tap #(
  parameter int DEPTH = 8  // Number of selectable taps.
) (
  // Clock and reset.
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  // Control.
  input  wire logic                     dly_en,
  input  wire logic [$clog2(DEPTH)-1:0] dly_code,
  // Pulse path.
  input  wire logic                     pulse_in,
  output logic                          pulse_out
);
  // The code must be able to address every tap and nothing beyond.
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("pulse_delay_tap: DEPTH must be a power of two of at least 2.");
    end
  end

  logic [DEPTH-1:0] line_q;  // Shift line of past input pulses.

  // The line shifts every cycle so that any tap is valid at once.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      line_q <= '0;
    end else begin
      line_q <= {line_q[DEPTH-2:0], pulse_in};
    end
  end

  // The output is registered; a code of zero adds no extra delay.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pulse_out <= 1'b0;
    end else if (dly_en && dly_code != '0) begin
      pulse_out <= line_q[dly_code - 1'b1];
    end else begin
      pulse_out <= pulse_in;
    end
  end
endmodule : pulse_delay_tap

// file: rtl/pll_lock_detect_divider_sync.sv
/*
  Reference and feedback dividers, sync pin reset, divider delays, digital
  lock detect with hysteresis, lock pin modes and pin output muxes.
  Assumes divider inputs and pins are synchronous one-cycle edge pulses.
*/
// What this block does
// - Sync pin resets R, A, B when enabled
// - Each divider path has enableable three-bit delay
// - Lock after programmed run of in-window cycles
// - Lock holds until one wide-error cycle
// - Unlock threshold wider than lock threshold
// - Window bit, antibacklash, counter set timing
// - Lock flag selectable onto three pins
// - Current-source mode sources while locked, shorts otherwise
// - Comparator readable on pins, either polarity
// - Analog lock output in two polarities
// - Fixed-divide with B=1 gives P alone
// - Fixed-divide with B>=3 gives P times B
// - Counter reset bits hold until cleared
// - Lock counter code zero needs five cycles
`include "pll_lock_consts.svh"
module pll_lock_detect_divider_sync #(
  parameter int DLY_TAPS = 8  // Taps of each divider delay cell.
) (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Register port.
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Clock path pulses and sync pin.
  input  wire logic       ref_in_edge,
  input  wire logic       vco_in_edge,
  input  wire logic       sync_n,
  // Lock pin and its comparator.
  input  wire logic       ld_cmp_in,
  output logic            lock_indicator_pin_o,
  output logic            lock_indicator_pin_oe,
  output logic            ld_cs_src,
  // Other pins.
  output logic            status_pin,
  output logic            reference_monitor_pin,
  output logic            ref_pfd_edge,
  output logic            fb_pfd_edge,
  output logic            irq
);
  initial begin
    if (DLY_TAPS != 8) begin
      $error("pll_lock_detect_divider_sync: three-bit delay code needs 8 taps.");
    end
  end

  // Software registers.
  logic [7:0]  r_lsb_q, r_msb_q, a_q, b_lsb_q, b_msb_q, pre_q;
  logic [7:0]  stat_sel_q, lock_cfg_q, sync_dly_q, ld_sel_q, reference_monitor_pin_sel_q;
  logic [7:0]  dly_en_q, irq_mask_q;
  logic [2:0]  irq_stat_q;          // Sticky event bits.
  // Divider and detector state.
  logic [13:0] r_cnt_q;             // Reference divider count.
  logic [18:0] n_cnt_q;             // Feedback divider count.
  logic [18:0] n_total;             // Feedback ratio.
  logic        r_pulse_q, n_pulse_q;
  logic        sync_active, r_hold, n_hold;
  pll_lock_pkg::gap_state_type gap_state_q;
  logic [7:0]  gap_cnt_q;           // Cycles since the leading edge.
  logic        res_valid_q;         // One detector cycle evaluated.
  logic [7:0]  res_gap_q;           // Gap of that cycle.
  logic [7:0]  run_q;               // Consecutive in-window cycles.
  logic        dld_q;               // Digital phase lock flag.
  logic        cmp_q;               // Previous comparator level.
  logic [7:0]  lock_need, lock_thr, unlock_thr;
  logic        digital_phase_lock_flag;
  logic        err_active;          // Phase error pulse, the analog lock source.
  logic        wr_lock_gain, wr_lock_loss;

  // Register writes; the reset bits stay set until software clears them.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r_lsb_q <= `REG_RESET; r_msb_q <= `REG_RESET; a_q <= `REG_RESET;
      b_lsb_q <= `REG_RESET; b_msb_q <= `REG_RESET; pre_q <= `REG_RESET;
      stat_sel_q <= `REG_RESET; lock_cfg_q <= `REG_RESET;
      sync_dly_q <= `REG_RESET; ld_sel_q <= `REG_RESET;
      reference_monitor_pin_sel_q <= `REG_RESET; dly_en_q <= `REG_RESET;
      irq_mask_q <= `REG_RESET;
    end else if (wr) begin
      unique case (addr)
        `ADDR_R_LSB:      r_lsb_q      <= wdata;
        `ADDR_R_MSB:      r_msb_q      <= wdata;
        `ADDR_A_CNT:      a_q          <= wdata;
        `ADDR_B_LSB:      b_lsb_q      <= wdata;
        `ADDR_B_MSB:      b_msb_q      <= wdata;
        `ADDR_PRESCALE:   pre_q        <= wdata;
        `ADDR_STATUS_SEL: stat_sel_q   <= wdata;
        `ADDR_LOCK_CFG:   lock_cfg_q   <= wdata;
        `ADDR_SYNC_DELAY: sync_dly_q   <= wdata;
        `ADDR_LD_SEL:     ld_sel_q     <= wdata;
        `ADDR_REFERENCE_MONITOR_PIN_SEL: reference_monitor_pin_sel_q <= wdata;
        `ADDR_IRQ_MASK:   irq_mask_q   <= wdata;
        `ADDR_DELAY_EN:   dly_en_q     <= wdata;
        default: ;
      endcase
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata <= `REG_RESET;
    end else if (rd) begin
      unique case (addr)
        `ADDR_R_LSB:       rdata <= r_lsb_q;
        `ADDR_R_MSB:       rdata <= {2'b00, r_msb_q[5:0]};
        `ADDR_A_CNT:       rdata <= {2'b00, a_q[5:0]};
        `ADDR_B_LSB:       rdata <= b_lsb_q;
        `ADDR_B_MSB:       rdata <= {3'b000, b_msb_q[4:0]};
        `ADDR_PRESCALE:    rdata <= pre_q;
        `ADDR_STATUS_SEL:  rdata <= stat_sel_q;
        `ADDR_LOCK_CFG:    rdata <= lock_cfg_q;
        `ADDR_SYNC_DELAY:  rdata <= sync_dly_q;
        `ADDR_LD_SEL:      rdata <= {2'b00, ld_sel_q[5:0]};
        `ADDR_REFERENCE_MONITOR_PIN_SEL:  rdata <= reference_monitor_pin_sel_q;
        `ADDR_LIVE_STATUS: rdata <= {5'b00000, sync_active, cmp_q, dld_q};
        `ADDR_IRQ_STATUS:  rdata <= {5'b00000, irq_stat_q};
        `ADDR_IRQ_MASK:    rdata <= irq_mask_q;
        `ADDR_DELAY_EN:    rdata <= {6'b000000, dly_en_q[1:0]};
        default:           rdata <= `REG_RESET;
      endcase
    end
  end

  // Counter holds: sync pin when enabled, the shared bit, or each own bit.
  assign sync_active = (sync_dly_q[`SYNC_MODE_BITS] != `SYNC_MODE_OFF) && !sync_n;
  assign r_hold = sync_active || pre_q[`PRE_SHARED_RST] || pre_q[`PRE_R_RST];
  assign n_hold = sync_active || pre_q[`PRE_SHARED_RST] || pre_q[`PRE_AB_RST];

  // Feedback ratio from prescaler mode, A and B.
  always_comb begin
    logic [18:0] p;
    logic [18:0] b;
    logic        fixed;
    p = 19'd2;
    fixed = 1'b0;
    b = {6'b000000, b_msb_q[4:0], b_lsb_q};
    unique case (pre_q[`PRE_MODE_BITS])
      `PRE_DM2:  p = 19'd2;
      `PRE_DM4:  p = 19'd4;
      `PRE_DM8:  p = 19'd8;
      `PRE_DM16: p = 19'd16;
      `PRE_DM32: p = 19'd32;
      `PRE_FD1:  begin p = 19'd1; fixed = 1'b1; end
      `PRE_FD2:  begin p = 19'd2; fixed = 1'b1; end
      `PRE_FD3:  begin p = 19'd3; fixed = 1'b1; end
    endcase
    if (fixed && b <= 19'd1) begin
      n_total = p;
    end else if (fixed) begin
      n_total = 19'(p * b);
    end else begin
      n_total = 19'(p * b + {13'b0, a_q[5:0]});
    end
    if (n_total == '0) begin
      n_total = 19'd1;
    end
  end

  // Reference divider: codes 0 and 1 both divide by one.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r_cnt_q <= '0;
      r_pulse_q <= 1'b0;
    end else if (r_hold) begin
      r_cnt_q <= '0;
      r_pulse_q <= 1'b0;
    end else begin
      r_pulse_q <= 1'b0;
      if (ref_in_edge) begin
        if (r_cnt_q + 14'd1 >= {r_msb_q[5:0], r_lsb_q}) begin
          r_cnt_q <= '0;
          r_pulse_q <= 1'b1;
        end else begin
          r_cnt_q <= r_cnt_q + 14'd1;
        end
      end
    end
  end

  // Feedback divider counting VCO edges up to the ratio.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      n_cnt_q <= '0;
      n_pulse_q <= 1'b0;
    end else if (n_hold) begin
      n_cnt_q <= '0;
      n_pulse_q <= 1'b0;
    end else begin
      n_pulse_q <= 1'b0;
      if (vco_in_edge) begin
        if (n_cnt_q + 19'd1 >= n_total) begin
          n_cnt_q <= '0;
          n_pulse_q <= 1'b1;
        end else begin
          n_cnt_q <= n_cnt_q + 19'd1;
        end
      end
    end
  end

  // Delay cells ahead of the detector inputs.
  pulse_delay_tap #(.DEPTH(DLY_TAPS)) u_r_delay (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .dly_en   (dly_en_q[`R_DLY_EN_BIT]),
    .dly_code (sync_dly_q[`R_DLY_BITS]),
    .pulse_in (r_pulse_q),
    .pulse_out(ref_pfd_edge)
  );
  pulse_delay_tap #(.DEPTH(DLY_TAPS)) u_n_delay (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .dly_en   (dly_en_q[`N_DLY_EN_BIT]),
    .dly_code (sync_dly_q[`N_DLY_BITS]),
    .pulse_in (n_pulse_q),
    .pulse_out(fb_pfd_edge)
  );

  // Lock window from window bit, antibacklash and counter field.
  always_comb begin
    unique case (lock_cfg_q[`LOCK_CNT_BITS])
      2'b00: lock_need = `LOCK_NEED_0;
      2'b01: lock_need = `LOCK_NEED_1;
      2'b10: lock_need = `LOCK_NEED_2;
      2'b11: lock_need = `LOCK_NEED_3;
    endcase
    lock_thr = (lock_cfg_q[`LOCK_WIN_BIT] ? `LOCK_THR_LOW : `LOCK_THR_HIGH)
             + {6'b000000, stat_sel_q[`ABP_BITS]};
    unlock_thr = {lock_thr[6:0], 1'b0} + 8'd1;
  end

  // Gap meter: one result per edge pair, saturating when an edge is missing.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gap_state_q <= pll_lock_pkg::GAP_IDLE;
      gap_cnt_q <= '0;
      res_valid_q <= 1'b0;
      res_gap_q <= '0;
    end else begin
      res_valid_q <= 1'b0;
      unique case (gap_state_q)
        pll_lock_pkg::GAP_IDLE: begin
          gap_cnt_q <= 8'd1;
          if (ref_pfd_edge && fb_pfd_edge) begin
            res_valid_q <= 1'b1;
            res_gap_q <= '0;
          end else if (ref_pfd_edge) begin
            gap_state_q <= pll_lock_pkg::GAP_WAIT_FB;
          end else if (fb_pfd_edge) begin
            gap_state_q <= pll_lock_pkg::GAP_WAIT_REF;
          end
        end
        pll_lock_pkg::GAP_WAIT_FB, pll_lock_pkg::GAP_WAIT_REF: begin
          if ((gap_state_q == pll_lock_pkg::GAP_WAIT_FB) ? fb_pfd_edge : ref_pfd_edge) begin
            res_valid_q <= 1'b1;
            res_gap_q <= gap_cnt_q;
            gap_state_q <= pll_lock_pkg::GAP_IDLE;
          end else if ((gap_state_q == pll_lock_pkg::GAP_WAIT_FB) ? ref_pfd_edge
                                                                   : fb_pfd_edge) begin
            res_valid_q <= 1'b1;
            res_gap_q <= `GAP_MAX;
            gap_cnt_q <= 8'd1;
          end else if (gap_cnt_q != `GAP_MAX) begin
            gap_cnt_q <= gap_cnt_q + 8'd1;
          end
        end
        default: gap_state_q <= pll_lock_pkg::GAP_IDLE;
      endcase
    end
  end
  assign err_active = (gap_state_q != pll_lock_pkg::GAP_IDLE);

  // Lock flag: a run of in-window cycles sets it, one wide cycle clears it.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dld_q <= 1'b0;
      run_q <= '0;
    end else if (lock_cfg_q[`DLD_DIS_BIT]) begin
      dld_q <= 1'b0;
      run_q <= '0;
    end else if (res_valid_q) begin
      if (dld_q) begin
        if (res_gap_q > unlock_thr) begin
          dld_q <= 1'b0;
          run_q <= '0;
        end
      end else if (res_gap_q <= lock_thr) begin
        if (run_q + 8'd1 >= lock_need) begin
          dld_q <= 1'b1;
        end
        run_q <= run_q + 8'd1;
      end else begin
        run_q <= '0;
      end
    end
  end
  assign digital_phase_lock_flag = dld_q;

  // Lock pin modes: level, current source, or open-drain phase pulses.
  always_comb begin
    lock_indicator_pin_o = 1'b0;
    lock_indicator_pin_oe = 1'b1;
    ld_cs_src = 1'b0;
    unique case (ld_sel_q[5:0])
      `PSEL_DLD: lock_indicator_pin_o = digital_phase_lock_flag;
      `PSEL_CURRENT_SRC: begin
        ld_cs_src = digital_phase_lock_flag;
        lock_indicator_pin_oe = !digital_phase_lock_flag;
      end
      `PSEL_ALD_NCH: lock_indicator_pin_oe = err_active;
      `PSEL_ALD_PCH: begin
        lock_indicator_pin_o = 1'b1;
        lock_indicator_pin_oe = err_active;
      end
      default: ;
    endcase
  end

  // Status and monitor pin muxes, with comparator in either polarity.
  always_comb begin
    unique case (stat_sel_q[`STAT_SEL_BITS])
      `PSEL_DLD:      status_pin = digital_phase_lock_flag;
      `PSEL_CMP_HIGH: status_pin = ld_cmp_in;
      `PSEL_CMP_LOW:  status_pin = !ld_cmp_in;
      default:        status_pin = 1'b0;
    endcase
    unique case ({1'b0, reference_monitor_pin_sel_q[4:0]})
      `PSEL_DLD:      reference_monitor_pin = digital_phase_lock_flag;
      `PSEL_CMP_HIGH: reference_monitor_pin = ld_cmp_in;
      `PSEL_CMP_LOW:  reference_monitor_pin = !ld_cmp_in;
      default:        reference_monitor_pin = 1'b0;
    endcase
  end

  // Sticky events; a new event wins over a clearing write of one.
  assign wr_lock_gain = res_valid_q && !dld_q && !lock_cfg_q[`DLD_DIS_BIT]
                        && res_gap_q <= lock_thr && run_q + 8'd1 >= lock_need;
  assign wr_lock_loss = dld_q && (lock_cfg_q[`DLD_DIS_BIT]
                        || (res_valid_q && res_gap_q > unlock_thr));
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_stat_q <= '0;
      cmp_q <= 1'b0;
    end else begin
      cmp_q <= ld_cmp_in;
      irq_stat_q <= (irq_stat_q & ~((wr && addr == `ADDR_IRQ_STATUS) ? wdata[2:0] : 3'b000))
                  | {ld_cmp_in && !cmp_q, wr_lock_loss, wr_lock_gain};
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q[2:0]);

  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_sync_reset; sync_active |=> r_cnt_q == '0 && n_cnt_q == '0; endproperty
  a_sync_reset: assert property (p_sync_reset) else $error("Sync did not clear counters.");
  property p_lock_rise; $rose(dld_q) |-> $past(res_valid_q) && $past(res_gap_q) <= $past(lock_thr)
    && $past(run_q) + 8'd1 >= $past(lock_need); endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("Lock set without full run.");
  property p_unlock; dld_q && res_valid_q && res_gap_q > unlock_thr |=> !dld_q; endproperty
  a_unlock: assert property (p_unlock) else $error("Lock held past wide error.");
  property p_hold; dld_q && !lock_cfg_q[`DLD_DIS_BIT] && !(res_valid_q && res_gap_q > unlock_thr)
    |=> dld_q; endproperty
  a_hold: assert property (p_hold) else $error("Lock dropped without wide error.");
  property p_hyst; unlock_thr > lock_thr; endproperty
  a_hyst: assert property (p_hyst) else $error("Unlock threshold not wider.");
  property p_cs; ld_sel_q[5:0] == `PSEL_CURRENT_SRC |-> ld_cs_src == dld_q
    && lock_indicator_pin_oe == !dld_q && !lock_indicator_pin_o; endproperty
  a_cs: assert property (p_cs) else $error("Current source mode wrong.");
  property p_need5; lock_cfg_q[`LOCK_CNT_BITS] == 2'b00 |-> lock_need == 8'd5; endproperty
  a_need5: assert property (p_need5) else $error("Code zero does not need five.");
  property p_run_clear; res_valid_q && !dld_q && res_gap_q > lock_thr |=> run_q == '0; endproperty
  a_run_clear: assert property (p_run_clear) else $error("Miss did not clear run.");
  property p_fd1; pre_q[`PRE_MODE_BITS] == `PRE_FD2 && {b_msb_q[4:0], b_lsb_q} == 13'd1
    |-> n_total == 19'd2; endproperty
  a_fd1: assert property (p_fd1) else $error("Bypass ratio wrong.");
  property p_hold_rst; pre_q[`PRE_R_RST] |=> r_cnt_q == '0 ##1 r_cnt_q == '0 || !pre_q[`PRE_R_RST];
  endproperty
  a_hold_rst: assert property (p_hold_rst) else $error("Reset bit did not hold R.");
  c_lock: cover property ($rose(dld_q));
  c_unlock: cover property ($fell(dld_q));
  c_sync: cover property (sync_active ##1 !sync_active);
endmodule : pll_lock_detect_divider_sync

// file: testbench/ref_vco_source.sv
/*
  Partner model: reference and VCO feedback edge pulses.
  Assumes one clock; all periods and offsets are in clock cycles.
*/
module ref_vco_source (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Pattern control from the bench.
  input  wire logic [7:0] ref_per,
  input  wire logic [7:0] vco_per,
  input  wire logic [7:0] vco_off,
  // One-cycle edge pulses.
  output logic            ref_in_edge,
  output logic            vco_in_edge
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] t_q;  // Free running time base.
  // Pulses change just after each edge, so the block sees them settled.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      t_q <= 16'h0000;
      ref_in_edge <= 1'b0;
      vco_in_edge <= 1'b0;
    end else begin
      t_q <= t_q + 16'h0001;
      ref_in_edge <= (int'(t_q) % int'(ref_per)) == 0;
      // The offset is taken modulo the period, so an offset of zero aligns both trains.
      vco_in_edge <= ((int'(t_q) + int'(vco_per) * 256 - int'(vco_off)) % int'(vco_per)) == 0;
    end
  end
endmodule : ref_vco_source

// file: testbench/tb_pll_lock_detect_divider_sync.sv
/*
  Self-checking bench for the lock detect and divider block.
  Assumes the partner source model and a 50 MHz clock.
*/
module tb_pll_lock_detect_divider_sync;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 0, nrst = 0, wr = 0, rd = 0, sync_n = 1, ld_cmp_in = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, rp = 20, vp = 20, vo = 10, d;
  logic       ref_e, vco_e, ld_o, ld_oe, cs, st, rm, rpe, fpe, irq;
  int         n_errors = 0, checks = 0, cyc = 0, k, b, c;
  always #10 clk_sys = ~clk_sys;
  ref_vco_source ref_vco_source_i (.clk_sys(clk_sys), .nrst(nrst), .ref_per(rp),
    .vco_per(vp), .vco_off(vo), .ref_in_edge(ref_e), .vco_in_edge(vco_e));
  pll_lock_detect_divider_sync pll_lock_detect_divider_sync_i (.clk_sys(clk_sys),
    .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ref_in_edge(ref_e), .vco_in_edge(vco_e), .sync_n(sync_n), .ld_cmp_in(ld_cmp_in),
    .lock_indicator_pin_o(ld_o), .lock_indicator_pin_oe(ld_oe), .ld_cs_src(cs),
    .status_pin(st), .reference_monitor_pin(rm), .ref_pfd_edge(rpe),
    .fb_pfd_edge(fpe), .irq(irq));
  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand from the cycle after the strobe until the next read.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    addr <= a; rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic cw(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cw
  // Moves the VCO offset ten cycles after a reference pulse, so a reference edge leads.
  task automatic set_off(input logic [7:0] v);
    do begin @(posedge clk_sys); #1; end while (ref_e !== 1'b1);
    repeat (10) @(posedge clk_sys);
    vo <= v;
  endtask : set_off
  // Counts reference detector pulses over n cycles.
  task automatic cnt_ref(input int n, output int m);
    m = 0;
    repeat (n) begin @(posedge clk_sys); #1 if (rpe === 1'b1) m++; end
  endtask : cnt_ref
  // Spacing of detector pulses; the second interval is kept.
  task automatic meas(input logic fb, output int p);
    #1;
    repeat (2) begin
      k = 0;
      while ((fb ? fpe : rpe) !== 1'b1 && k < 300) begin @(posedge clk_sys); #1 k++; end
      p = 0;
      do begin @(posedge clk_sys); #1 p++; end while ((fb ? fpe : rpe) !== 1'b1 && p < 300);
    end
  endtask : meas
  // Cycles from a reference input pulse to its detector pulse.
  task automatic lat(output int p);
    #1;
    k = 0;
    while (ref_e !== 1'b1 && k < 300) begin @(posedge clk_sys); #1 k++; end
    p = 0;
    do begin @(posedge clk_sys); #1 p++; end while (rpe !== 1'b1 && p < 40);
  endtask : lat
  // Feedback period expected in fixed-divide mode.
  function automatic logic [7:0] fb_exp(input int p, input int bb, input int per);
    return 8'((bb <= 1 ? p : p * bb) * per);
  endfunction : fb_exp
  // Bounds a hang.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin n_errors++; test_done(); end
  end
  initial begin
    void'($urandom(32));
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    cw(2);
    for (int a = 8'h17; a <= 8'h1b; a++) begin rd_reg(8'(a), d); chk(d, 8'h00); end
    rd_reg(8'h30, d); chk(d, 8'h00);
    chk({ld_oe, ld_o}, 8'h02);
    wr_reg(8'h16, 8'h05); wr_reg(8'h14, 8'h01);
    sync_n <= 1'b0;
    cnt_ref(60, k); chk(8'(k), 8'h03);
    wr_reg(8'h19, 8'h40);
    cw(2);
    cnt_ref(60, k); chk(8'(k), 8'h00);
    sync_n <= 1'b1;
    wr_reg(8'h19, 8'h00); wr_reg(8'h16, 8'h25);
    cw(2);
    cnt_ref(60, k); chk(8'(k), 8'h00);
    rd_reg(8'h16, d); chk(d, 8'h25);
    vp <= 4; wr_reg(8'h16, 8'h06);
    meas(1, k); chk(8'(k), fb_exp(2, 1, 4));
    wr_reg(8'h14, 8'h03);
    meas(1, k); chk(8'(k), fb_exp(2, 3, 4));
    vp <= 20; wr_reg(8'h16, 8'h05); wr_reg(8'h14, 8'h01);
    lat(b); wr_reg(8'h23, 8'h01); wr_reg(8'h19, 8'h07);
    lat(k); chk(8'(k), 8'(b + 7));
    wr_reg(8'h19, 8'h00);
    lat(k); chk(8'(k), 8'(b));
    wr_reg(8'h23, 8'h00);
    wr_reg(8'h1a, 8'h01); wr_reg(8'h17, 8'h04); wr_reg(8'h1b, 8'h01); wr_reg(8'h22, 8'h02);
    cw(60); chk({ld_o, st, rm}, 8'h00);
    set_off(8'h00);
    cw(50); chk({ld_o, st, rm}, 8'h00);
    cw(150); chk({ld_o, st, rm}, 8'h07);
    set_off(8'h05);
    cw(100); chk({ld_o, st, rm}, 8'h07);
    wr_reg(8'h1a, 8'h04);
    cw(2); chk(cs, 1'b1);
    set_off(8'h09);
    cw(60); chk({cs, st, rm}, 8'h00);
    chk(irq, 1'b1);
    rd_reg(8'h21, d); chk(d & 8'h02, 8'h02);
    wr_reg(8'h21, 8'h02);
    cw(2); chk(irq, 1'b0);
    wr_reg(8'h18, 8'h10); set_off(8'h02);
    cw(200); chk(st, 1'b0);
    wr_reg(8'h17, 8'h05);
    cw(200); chk(st, 1'b1);
    // A two-cycle phase error per twenty-cycle period gives six pulse cycles in sixty.
    wr_reg(8'h1a, 8'h06); c = 0;
    repeat (60) begin @(posedge clk_sys); #1 c += int'(ld_oe); end
    chk(8'(c), 8'h06);
    chk(ld_o, 1'b1);
    repeat (8) begin
      c = $urandom % 2;
      wr_reg(8'h17, c ? 8'h0c : 8'h08); wr_reg(8'h1b, c ? 8'h03 : 8'h02);
      ld_cmp_in <= 1'($urandom);
      cw(3); chk({st, rm}, {2{ld_cmp_in ^ c[0]}});
    end
    for (int a = 8'h17; a <= 8'h1b; a++) begin
      b = $urandom;
      wr_reg(8'(a), 8'(b)); rd_reg(8'(a), d);
      chk(d, 8'(b) & ((a == 8'h1a) ? 8'h3f : 8'hff));
    end
    test_done();
  end
endmodule : tb_pll_lock_detect_divider_sync
